// ### common/irq_prio_pkg.sv
package irq_prio_pkg;
  localparam int num_src = 40;
  localparam int src_w = 6;
  localparam int lvl_w = 3;
  localparam int pc_w = 32;
  localparam int code_w = 16;
  localparam logic [pc_w-1:0] pc_step = 32'h0000_0004;
  localparam logic [code_w-1:0] code_base = 16'h0080;
  localparam logic [code_w-1:0] code_step = 16'h0010;
  localparam logic [code_w-1:0] code_gap = 16'h0040;
  localparam int gap_from = 8;
  localparam logic [code_w-1:0] code_nmi_pin = 16'h0010;
  localparam logic [code_w-1:0] code_nmi_wdog = 16'h0020;
  localparam logic [code_w-1:0] code_illegal = 16'h0060;
  localparam logic [code_w-1:0] code_trap0 = 16'h0040;
  localparam logic [code_w-1:0] code_trap1 = 16'h0050;
  localparam logic [pc_w-1:0] reset_pc = 32'h0000_0000;
  localparam logic [lvl_w-1:0] lowest_level = 3'h7;
  localparam int prio_wdog = 0;
  localparam int prio_csi0_i2c = 19;
  localparam int prio_uart0_rx_csi1 = 21;
  localparam int prio_i2c_ch1 = 24;
  localparam int prio_vehbus_xfer = 29;
  localparam int prio_vehbus_comm = 30;
  localparam int prio_dma_first = 32;
  localparam int prio_dma_last = 37;
  localparam int prio_key_return = 39;
  localparam int prio_timer2 = 13;
  localparam int prio_timer7 = 18;
endpackage

// ### src/irq_flag_cell.sv
`timescale 1ns/100ps
// One pending flag: set wins over clear in the same cycle
module irq_flag_cell (
  input wire logic mclk,
  input wire logic srst,
  input wire logic present,
  input wire logic set_req,
  input wire logic clr_req,
  output logic pending
);
  logic next_pending;

  always_comb begin
    next_pending = pending;
    if (clr_req) begin
      next_pending = 1'b0;
    end
    if (set_req) begin
      next_pending = 1'b1;
    end
    if (!present) begin
      next_pending = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end
endmodule // irq_flag_cell

// ### src/irq_vector_resolver.sv
`timescale 1ns/100ps
// How it works
// [RL1] Simultaneous requests resolved by default priority, 0 highest
// [RL2] Save restored PC to matching save register
// [RL3] Interrupt during divide saves divide's own address
// [RL4] Illegal opcode: saved PC minus 4 is offender
// [RL5] Saved PC is next instruction address
// [RL6] Watchdog overflow goes one path only
// [RL7] I2C sources exist only with I2C option
// [RL8] Vehicle-bus sources 29, 30 only in large variant
// [RL9] Key return lowest priority 39, code 0330h
// [RL10] DMA done sources at 32..37, 02c0h..0310h
// [RL11] Timers 2..7 one request each, 13..18
// [RL12] Acknowledge writes cause half and loads handler
// [RL13] Route bit 0 makes watchdog maskable priority 0
// [RL14] Programmable level checked before default priority
// [RL15] Requests held pending until acknowledged or cleared
module irq_vector_resolver
  import irq_prio_pkg::*;
#(
  parameter bit has_i2c = 1'b1,
  parameter bit has_vehbus = 1'b1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [irq_prio_pkg::num_src-1:0] src_req,
  input wire logic [irq_prio_pkg::num_src-1:0] src_mask,
  input wire logic [irq_prio_pkg::num_src*irq_prio_pkg::lvl_w-1:0] src_level,
  input wire logic [irq_prio_pkg::num_src-1:0] sw_clear,
  input wire logic i2c_ch0_irq,
  input wire logic csi0_tx_done_irq,
  input wire logic uart0_rx_done_irq,
  input wire logic clk_serial1_tx_done_irq,
  input wire logic wdog_overflow,
  input wire logic wdog_irq_route_bit,
  input wire logic int_enable,
  input wire logic nmi_pin_req,
  input wire logic nmi_busy,
  input wire logic [irq_prio_pkg::lvl_w-1:0] cur_level,
  input wire logic cpu_ready,
  input wire logic [irq_prio_pkg::pc_w-1:0] cur_pc,
  input wire logic [irq_prio_pkg::pc_w-1:0] next_pc,
  input wire logic halfword_divide_instr,
  input wire logic illegal_opcode_trap,
  input wire logic trap_req,
  input wire logic [4:0] trap_num,
  output logic [irq_prio_pkg::num_src-1:0] pending,
  output logic wdog_overflow_nonmaskable_irq,
  output logic take,
  output logic take_nonmaskable,
  output logic [irq_prio_pkg::src_w-1:0] taken_src,
  output logic [irq_prio_pkg::lvl_w-1:0] taken_level,
  output logic [irq_prio_pkg::pc_w-1:0] maskable_saved_pc,
  output logic [irq_prio_pkg::pc_w-1:0] nonmaskable_saved_pc,
  output logic [irq_prio_pkg::code_w-1:0] maskable_cause_half,
  output logic [irq_prio_pkg::code_w-1:0] nonmaskable_cause_half,
  output logic [irq_prio_pkg::pc_w-1:0] handler_pc
);

  // Code for a maskable source; 8..39 sit after a gap of four vectors
  function automatic logic [code_w-1:0] src_code(input logic [src_w-1:0] s);
    logic [code_w-1:0] c;
    c = code_base + code_step * code_w'(s);
    if (int'(s) >= gap_from) begin
      c = c + code_gap;
    end
    return c;
  endfunction

  function automatic logic [lvl_w-1:0] lvl_of(input logic [src_w-1:0] s,
                                              input logic [num_src*lvl_w-1:0] v);
    return v[int'(s)*lvl_w +: lvl_w];
  endfunction

  logic [num_src-1:0] present;
  logic [num_src-1:0] raw_set;
  logic wdog_maskable;
  logic [num_src-1:0] ack_clr;

  // [RL6] exclusive watchdog route
  assign wdog_maskable = wdog_overflow & ~wdog_irq_route_bit;
  assign wdog_overflow_nonmaskable_irq = wdog_overflow & wdog_irq_route_bit;

  always_comb begin
    present = '1;
    // [RL7] I2C option only
    present[prio_i2c_ch1] = has_i2c;
    // [RL8] vehicle-bus variant only
    present[prio_vehbus_xfer] = has_vehbus;
    present[prio_vehbus_comm] = has_vehbus;
    raw_set = src_req;
    // [RL13] maskable watchdog slot
    raw_set[prio_wdog] = wdog_maskable;
    // [RL15] shared vector flags
    raw_set[prio_csi0_i2c] = csi0_tx_done_irq | (i2c_ch0_irq & has_i2c);
    raw_set[prio_uart0_rx_csi1] = uart0_rx_done_irq | clk_serial1_tx_done_irq;
  end

  // [RL15] sticky pending flags
  // [RL11] timers 2..7 map one line each at 13..18
  // [RL10] DMA lines at 32..37
  for (genvar i = 0; i < num_src; i++) begin : g_flag
    irq_flag_cell u_flag (
      .mclk(mclk),
      .srst(srst),
      .present(present[i]),
      .set_req(raw_set[i]),
      .clr_req(sw_clear[i] | ack_clr[i]),
      .pending(pending[i])
    );
  end

  logic sel_valid;
  logic [src_w-1:0] sel_src;
  logic [lvl_w-1:0] sel_lvl;

  // [RL14] level first, then default order
  // [RL1] lower index wins ties
  always_comb begin
    sel_valid = 1'b0;
    sel_src = '0;
    sel_lvl = lowest_level;
    for (int i = 0; i < num_src; i++) begin
      if (pending[i] && !src_mask[i]) begin
        if (!sel_valid || lvl_of(src_w'(i), src_level) < sel_lvl) begin
          sel_valid = 1'b1;
          sel_src = src_w'(i);
          sel_lvl = lvl_of(src_w'(i), src_level);
        end
      end
    end
  end

  typedef enum logic [2:0] {
    ev_none = 3'h1,
    ev_nmi = 3'h2,
    ev_mask = 3'h4
  } ev_t;

  logic [1:0] nmi_latch;
  logic [1:0] next_nmi_latch;
  ev_t ev;
  logic [pc_w-1:0] restored_pc;
  logic maskable_ok;
  logic next_take;
  logic next_take_nm;
  logic [src_w-1:0] next_taken_src;
  logic [lvl_w-1:0] next_taken_level;
  logic [pc_w-1:0] next_mpc;
  logic [pc_w-1:0] next_npc;
  logic [code_w-1:0] next_mcause;
  logic [code_w-1:0] next_ncause;
  logic [pc_w-1:0] next_handler;

  assign maskable_ok = sel_valid && int_enable && !nmi_busy && (sel_lvl < cur_level || cur_level == lowest_level);

  // [RL3] divide restarts
  // [RL5] otherwise next instruction
  // [RL4] trap leaves offender at saved minus 4
  always_comb begin
    if (halfword_divide_instr && !illegal_opcode_trap && !trap_req) begin
      restored_pc = cur_pc;
    end else if (illegal_opcode_trap) begin
      restored_pc = cur_pc + pc_step;
    end else begin
      restored_pc = next_pc;
    end
  end

  always_comb begin
    next_nmi_latch = nmi_latch;
    if (nmi_pin_req) begin
      next_nmi_latch[0] = 1'b1;
    end
    if (wdog_overflow_nonmaskable_irq) begin
      next_nmi_latch[1] = 1'b1;
    end
    ack_clr = '0;
    next_take = 1'b0;
    next_take_nm = 1'b0;
    next_taken_src = taken_src;
    next_taken_level = taken_level;
    next_mpc = maskable_saved_pc;
    next_npc = nonmaskable_saved_pc;
    next_mcause = maskable_cause_half;
    next_ncause = nonmaskable_cause_half;
    next_handler = handler_pc;
    ev = ev_none;
    if (cpu_ready && !nmi_busy && (nmi_latch != 2'h0)) begin
      ev = ev_nmi;
    end else if (cpu_ready && (illegal_opcode_trap || trap_req)) begin
      ev = ev_mask;
    end else if (cpu_ready && maskable_ok) begin
      ev = ev_mask;
    end
    case (ev)
      ev_nmi: begin
        // [RL2] non-maskable save
        next_take_nm = 1'b1;
        next_npc = restored_pc;
        if (nmi_latch[0]) begin
          next_nmi_latch[0] = nmi_pin_req;
          next_ncause = code_nmi_pin;
        end else begin
          next_nmi_latch[1] = wdog_overflow_nonmaskable_irq;
          next_ncause = code_nmi_wdog;
        end
        next_handler = pc_w'(next_ncause);
      end
      ev_mask: begin
        // [RL2] maskable save
        // [RL12] cause half and handler
        next_take = 1'b1;
        next_mpc = restored_pc;
        if (illegal_opcode_trap) begin
          next_mcause = code_illegal;
          next_handler = pc_w'(code_illegal);
        end else if (trap_req) begin
          next_mcause = (trap_num[4] ? code_trap1 : code_trap0) | code_w'(trap_num[3:0]);
          next_handler = pc_w'(trap_num[4] ? code_trap1 : code_trap0);
        end else begin
          // [RL9] key return code via table position
          next_mcause = src_code(sel_src);
          next_handler = pc_w'(src_code(sel_src));
          next_taken_src = sel_src;
          next_taken_level = sel_lvl;
          ack_clr[sel_src] = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      nmi_latch <= 2'h0;
      take <= 1'b0;
      take_nonmaskable <= 1'b0;
      taken_src <= '0;
      taken_level <= lowest_level;
      maskable_saved_pc <= reset_pc;
      nonmaskable_saved_pc <= reset_pc;
      maskable_cause_half <= '0;
      nonmaskable_cause_half <= '0;
      handler_pc <= reset_pc;
    end else begin
      nmi_latch <= next_nmi_latch;
      take <= next_take;
      take_nonmaskable <= next_take_nm;
      taken_src <= next_taken_src;
      taken_level <= next_taken_level;
      maskable_saved_pc <= next_mpc;
      nonmaskable_saved_pc <= next_npc;
      maskable_cause_half <= next_mcause;
      nonmaskable_cause_half <= next_ncause;
      handler_pc <= next_handler;
    end
  end
endmodule // irq_vector_resolver

// ### dv/cpu_pc_model.sv
`timescale 1ns/100ps
module cpu_pc_model
  import irq_prio_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic take,
  input wire logic take_nonmaskable,
  input wire logic [irq_prio_pkg::pc_w-1:0] handler_pc,
  output logic [irq_prio_pkg::pc_w-1:0] cur_pc,
  output logic [irq_prio_pkg::pc_w-1:0] next_pc
);
  // Pc only moves on an accept, so the bench can read it just before each one
  always_ff @(posedge mclk) begin
    if (srst) begin
      cur_pc <= 32'h0000_1000;
    end else if (take || take_nonmaskable) begin
      cur_pc <= handler_pc + 32'h0000_0008;
    end
  end
  assign next_pc = cur_pc + pc_step;
endmodule // cpu_pc_model

// ### dv/irq_resolver_chk.sv
`timescale 1ns/100ps
module irq_resolver_chk
  import irq_prio_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic cpu_ready,
  input wire logic [irq_prio_pkg::pc_w-1:0] cur_pc,
  input wire logic [irq_prio_pkg::pc_w-1:0] next_pc,
  input wire logic halfword_divide_instr,
  input wire logic illegal_opcode_trap,
  input wire logic wdog_overflow,
  input wire logic wdog_irq_route_bit,
  input wire logic [irq_prio_pkg::num_src-1:0] pending,
  input wire logic wdog_overflow_nonmaskable_irq,
  input wire logic take,
  input wire logic take_nonmaskable,
  input wire logic [irq_prio_pkg::pc_w-1:0] maskable_saved_pc,
  input wire logic [irq_prio_pkg::pc_w-1:0] nonmaskable_saved_pc,
  input wire logic [irq_prio_pkg::code_w-1:0] maskable_cause_half,
  input wire logic [irq_prio_pkg::pc_w-1:0] handler_pc
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_take_needs_ready: assert property (take |-> $past(cpu_ready))
    else $error("accept without ready");
  a_wdog_one_path: assert property (wdog_overflow_nonmaskable_irq == (wdog_overflow && wdog_irq_route_bit))
    else $error("watchdog routing wrong");
  a_wdog_slot_zero: assert property ($rose(pending[0]) |-> !$past(wdog_irq_route_bit))
    else $error("watchdog pended while nonmaskable");
  a_handler_from_code: assert property (take && maskable_cause_half[15:7] != 9'h0 |->
    handler_pc == {16'h0000, maskable_cause_half})
    else $error("handler differs from code");
  a_divide_restart: assert property (take && $past(halfword_divide_instr) && !$past(illegal_opcode_trap) |->
    maskable_saved_pc == $past(cur_pc))
    else $error("divide pc wrong");
  a_illegal_pc: assert property (take && $past(illegal_opcode_trap) |->
    maskable_saved_pc == $past(cur_pc) + 32'h0000_0004 && maskable_cause_half == 16'h0060)
    else $error("illegal opcode pc wrong");
  a_next_pc_saved: assert property (take && !$past(halfword_divide_instr) && !$past(illegal_opcode_trap) |->
    maskable_saved_pc == $past(next_pc))
    else $error("saved pc not next");
  a_nmi_save_reg: assert property (take_nonmaskable && !$past(halfword_divide_instr) |->
    nonmaskable_saved_pc == $past(next_pc) && !take)
    else $error("nonmaskable save wrong");
  c_nmi: cover property (take_nonmaskable);
  c_back_to_back: cover property (take ##2 take);
  c_divide: cover property (take && $past(halfword_divide_instr));
endmodule // irq_resolver_chk

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import irq_prio_pkg::*;
  logic mclk, srst, int_enable, nmi_pin_req, nmi_busy, cpu_ready, halfword_divide_instr, illegal_opcode_trap;
  logic trap_req, i2c_ch0_irq, csi0_tx_done_irq, uart0_rx_done_irq, clk_serial1_tx_done_irq;
  logic wdog_overflow, wdog_irq_route_bit, wdog_overflow_nonmaskable_irq, take, take_nonmaskable;
  logic [num_src-1:0] src_req, src_mask, sw_clear, pending, lite_pending;
  logic [num_src*lvl_w-1:0] src_level;
  logic [lvl_w-1:0] cur_level, taken_level;
  logic [4:0] trap_num;
  logic [src_w-1:0] taken_src;
  logic [pc_w-1:0] cur_pc, next_pc, maskable_saved_pc, nonmaskable_saved_pc, handler_pc;
  logic [code_w-1:0] maskable_cause_half, nonmaskable_cause_half;
  int n_fail, checks;
  int q[8] = '{13, 18, 24, 29, 30, 32, 37, 39};
  irq_vector_resolver dut_u (.*);
  cpu_pc_model cpu_u (.*);
  // Variant without the I2C and vehicle-bus options, fed the same stimulus
  irq_vector_resolver #(.has_i2c(1'b0), .has_vehbus(1'b0)) dut_lite_u (
    .mclk(mclk), .srst(srst), .src_req(src_req), .src_mask(src_mask), .src_level(src_level),
    .sw_clear(sw_clear), .i2c_ch0_irq(i2c_ch0_irq), .csi0_tx_done_irq(csi0_tx_done_irq),
    .uart0_rx_done_irq(uart0_rx_done_irq), .clk_serial1_tx_done_irq(clk_serial1_tx_done_irq),
    .wdog_overflow(wdog_overflow), .wdog_irq_route_bit(wdog_irq_route_bit), .int_enable(int_enable),
    .nmi_pin_req(nmi_pin_req), .nmi_busy(nmi_busy), .cur_level(cur_level), .cpu_ready(cpu_ready),
    .cur_pc(cur_pc), .next_pc(next_pc), .halfword_divide_instr(halfword_divide_instr),
    .illegal_opcode_trap(illegal_opcode_trap), .trap_req(trap_req), .trap_num(trap_num),
    .pending(lite_pending), .wdog_overflow_nonmaskable_irq(), .take(), .take_nonmaskable(),
    .taken_src(), .taken_level(), .maskable_saved_pc(), .nonmaskable_saved_pc(),
    .maskable_cause_half(), .nonmaskable_cause_half(), .handler_pc()
  );
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task raise(input logic [39:0] v);
    src_req <= v;
    @(posedge mclk);
    src_req <= '0;
    @(posedge mclk);
  endtask
  // Mode 0 expects next pc, 1 the current pc, 2 current pc plus 4; s of 63 skips the source check
  task grab(input bit nm, input int s, input logic [15:0] c, input logic [31:0] h, input int mode);
    logic [31:0] pc;
    cpu_ready <= 1'b1;
    @(posedge mclk);
    cpu_ready <= 1'b0;
    #1;
    pc = (mode == 1) ? cur_pc : cur_pc + 32'h4;
    chk(32'(nm ? take_nonmaskable : take), 32'h1);
    chk(32'(nm ? nonmaskable_cause_half : maskable_cause_half), 32'(c));
    chk(nm ? nonmaskable_saved_pc : maskable_saved_pc, pc);
    chk(handler_pc, h);
    if (!nm && s != 63) chk(32'(taken_src), 32'(s));
    @(posedge mclk);
  endtask
  task t_order;
    src_mask[5] <= 1'b1;
    raise((40'h1 << 5) | (40'h1 << 13) | (40'h1 << 18) | (40'h1 << 24) | (40'h1 << 29) | (40'h1 << 30) |
      (40'h1 << 32) | (40'h1 << 37) | (40'h1 << 39));
    chk(32'({lite_pending[30:29], lite_pending[24], lite_pending[13]}), 32'h1);
    for (int k = 0; k < 8; k++) begin
      grab(1'b0, q[k], 16'(q[k] * 16 + 192), 32'(q[k] * 16 + 192), 0);
    end
    chk(32'(pending), 32'h20);
    sw_clear[5] <= 1'b1;
    @(posedge mclk);
    sw_clear[5] <= 1'b0;
    @(posedge mclk);
    chk(32'(pending[5]), 32'h0);
    uart0_rx_done_irq <= 1'b1;
    @(posedge mclk);
    uart0_rx_done_irq <= 1'b0;
    @(posedge mclk);
    grab(1'b0, 21, 16'h0210, 32'h210, 0);
    clk_serial1_tx_done_irq <= 1'b1;
    i2c_ch0_irq <= 1'b1;
    @(posedge mclk);
    {clk_serial1_tx_done_irq, i2c_ch0_irq} <= 2'b00;
    @(posedge mclk);
    chk(32'({pending[21], pending[19], lite_pending[19]}), 32'h6);
    grab(1'b0, 19, 16'h01f0, 32'h1f0, 0);
    grab(1'b0, 21, 16'h0210, 32'h210, 0);
    csi0_tx_done_irq <= 1'b1;
    @(posedge mclk);
    csi0_tx_done_irq <= 1'b0;
    @(posedge mclk);
    grab(1'b0, 19, 16'h01f0, 32'h1f0, 0);
  endtask
  task t_wdog;
    wdog_overflow <= 1'b1;
    @(posedge mclk);
    wdog_overflow <= 1'b0;
    @(posedge mclk);
    grab(1'b0, 0, 16'h0080, 32'h80, 0);
    wdog_irq_route_bit <= 1'b1;
    wdog_overflow <= 1'b1;
    @(posedge mclk);
    #1;
    chk(32'(wdog_overflow_nonmaskable_irq), 32'h1);
    wdog_overflow <= 1'b0;
    @(posedge mclk);
    chk(32'(pending[0]), 32'h0);
    grab(1'b1, 0, 16'h0020, 32'h20, 0);
    nmi_pin_req <= 1'b1;
    @(posedge mclk);
    nmi_pin_req <= 1'b0;
    grab(1'b1, 0, 16'h0010, 32'h10, 0);
  endtask
  task t_pcs;
    halfword_divide_instr <= 1'b1;
    raise(40'h2);
    grab(1'b0, 1, 16'h0090, 32'h90, 1);
    halfword_divide_instr <= 1'b0;
    illegal_opcode_trap <= 1'b1;
    grab(1'b0, 63, 16'h0060, 32'h60, 2);
    illegal_opcode_trap <= 1'b0;
    trap_req <= 1'b1;
    trap_num <= 5'h05;
    grab(1'b0, 63, 16'h0045, 32'h40, 0);
    trap_req <= 1'b0;
  endtask
  task t_level;
    cur_level <= 3'h2;
    src_level[27+:3] <= 3'h4;
    src_level[36+:3] <= 3'h1;
    raise((40'h1 << 9) | (40'h1 << 12));
    grab(1'b0, 12, 16'h0180, 32'h180, 0);
    chk(32'(taken_level), 32'h1);
    chk(32'(pending[9]), 32'h1);
    cpu_ready <= 1'b1;
    @(posedge mclk);
    cpu_ready <= 1'b0;
    #1;
    chk(32'(take), 32'h0);
    @(posedge mclk);
    cur_level <= 3'h7;
    grab(1'b0, 9, 16'h0150, 32'h150, 0);
    chk(32'(taken_level), 32'h4);
  endtask
  initial begin
    {int_enable, srst} = 2'b11;
    {nmi_pin_req, nmi_busy, cpu_ready, halfword_divide_instr, illegal_opcode_trap, trap_req} = '0;
    {i2c_ch0_irq, csi0_tx_done_irq, uart0_rx_done_irq, clk_serial1_tx_done_irq} = '0;
    {wdog_overflow, wdog_irq_route_bit, src_req, src_mask, sw_clear, src_level, trap_num} = '0;
    cur_level = 3'h7;
    n_fail = 0;
    checks = 0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_order;
    t_wdog;
    t_pcs;
    t_level;
    tally_and_finish;
  end
endmodule // testbench
bind irq_vector_resolver irq_resolver_chk chk_u (.*);
